// *** hdl/plc_tc_pkg.sv ***
package plc_tc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int HUND_TICK_NS   = 10_000_000;
  localparam int HUND_TICK_CYC  = HUND_TICK_NS / CLK_PERIOD_NS;
  localparam int TENTH_PER_HUND = 10;

  // ****************************************
  // Storage word map
  // ****************************************
  localparam logic [11:0] TMR_BASE = 12'h000;
  localparam logic [11:0] CNT_BASE = 12'h3e8;
  localparam logic [11:0] PRE_BASE = 12'h800;

  localparam logic [11:0] T_TENTH     = 12'h000;
  localparam logic [11:0] T_HUND      = 12'h001;
  localparam logic [11:0] T_ACC_TENTH = 12'h002;
  localparam logic [11:0] T_ACC_HUND  = 12'h004;
  localparam logic [11:0] C_UP        = 12'h000;
  localparam logic [11:0] C_UD        = 12'h001;
  localparam logic [11:0] C_STG       = 12'h003;

  localparam int PRE_WORDS   = 10;
  localparam int P_TENTH     = 0;
  localparam int P_HUND      = 1;
  localparam int P_ACC_TENTH = 2;
  localparam int P_ACC_HUND  = 4;
  localparam int P_UP        = 6;
  localparam int P_UD        = 7;
  localparam int P_STG       = 9;

  localparam logic [15:0] PRE_RST  = 16'h9999;
  localparam logic [15:0] WORD_MAX = 16'h9999;
  localparam logic [31:0] DWRD_MAX = 32'h9999_9999;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic tenth_en;
    logic hund_en;
    logic acc_tenth_en;
    logic acc_tenth_rst;
    logic acc_hund_en;
    logic acc_hund_rst;
    logic up_in;
    logic up_rst;
    logic ud_up;
    logic ud_down;
    logic ud_rst;
    logic stg_in;
    logic stg_rst;
  } rung_in_t;

  typedef struct packed {
    logic tenth;
    logic hund;
    logic acc_tenth;
    logic acc_hund;
    logic up;
    logic ud;
    logic stg;
  } done_t;

  // ****************************************
  // Packed decimal helpers
  // ****************************************
  function automatic logic [31:0] bcd_inc(input logic [31:0] v,
                                          input int          nd);
    logic [31:0] r;
    logic        c;
    logic        full;
    r    = v;
    c    = 1'b1;
    full = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i < nd && v[4*i +: 4] != 4'h9) full = 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      if (i < nd && c && !full) begin
        if (r[4*i +: 4] == 4'h9) begin
          r[4*i +: 4] = 4'h0;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] bcd_dec(input logic [31:0] v);
    logic [31:0] r;
    logic        b;
    r = v;
    b = (v != 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      if (b) begin
        if (r[4*i +: 4] == 4'h0) begin
          r[4*i +: 4] = 4'h9;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] - 4'h1;
          b = 1'b0;
        end
      end
    end
    return r;
  endfunction

endpackage

// *** hdl/plc_timer_counter_unit.sv ***
// Function
// - Tenth timer runs while input on, clears off
// - Hundredth timer behaves alike, 99.99 s
// - Input drop zeroes value, done goes off
// - Accumulating tenth timer saturates at 9999999.9
// - Accumulating hundredth timer limit 999999.99
// - Accumulator advances only when enabled, keeps value
// - Accumulator reset holds zero, clears done
// - Timer done when value at least preset
// - Accumulator uses two words, two numbers
// - Timer value readable at timer number
// - Timer preset writable while running
// - Up counter increments on count rising edge
// - Up counter reset forces zero, status off
// - Up counter status at preset, holds 9999
// - Counter value at number plus 1000
// - Counter status when value at least preset
// - Counter preset writable while running
// - Up/down counter, three inputs, to 99999999
// - Up/down steps only with others inactive
// - Stage counter counts edges, keeps until reset
// - Stage counter status at preset, holds 9999
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module plc_timer_counter_unit
  import plc_tc_pkg::*;
#(
  parameter int HUND_CYC = HUND_TICK_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [11:0] ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire rung_in_t    RUNG,
  output done_t            DONE
);

  // ****************************************
  // Time base dividers
  // ****************************************
  localparam int DW = $clog2(HUND_CYC);

  logic [DW-1:0] hund_div_reg;
  logic [3:0]    tenth_div_reg;
  logic          hund_tick;
  logic          tenth_tick;

  assign hund_tick  = (hund_div_reg == DW'(HUND_CYC - 1));
  assign tenth_tick = hund_tick &&
                      (tenth_div_reg == 4'(TENTH_PER_HUND - 1));

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hund_div_reg <= '0;
    end else if (hund_tick) begin
      hund_div_reg <= '0;
    end else begin
      hund_div_reg <= hund_div_reg + DW'(1);
    end
  end

  // Tenth tick falls on a hundredth tick, so both bases stay in phase
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tenth_div_reg <= 4'h0;
    end else if (tenth_tick) begin
      tenth_div_reg <= 4'h0;
    end else if (hund_tick) begin
      tenth_div_reg <= tenth_div_reg + 4'h1;
    end
  end

  // ****************************************
  // Presets
  // ****************************************
  logic [15:0] pre_reg [PRE_WORDS];
  logic        pre_hit;
  logic [11:0] pre_idx;

  assign pre_idx = ADDR - PRE_BASE;
  assign pre_hit = (ADDR >= PRE_BASE) &&
                   (pre_idx < 12'(PRE_WORDS));

  // Writable at any time; the units compare against the live value
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < PRE_WORDS; i++) pre_reg[i] <= PRE_RST;
    end else if (WR && pre_hit) begin
      pre_reg[pre_idx[3:0]] <= WDATA;
    end
  end

  logic [31:0] pre_acc_tenth;
  logic [31:0] pre_acc_hund;
  logic [31:0] pre_ud;

  assign pre_acc_tenth = {pre_reg[P_ACC_TENTH+1], pre_reg[P_ACC_TENTH]};
  assign pre_acc_hund  = {pre_reg[P_ACC_HUND+1], pre_reg[P_ACC_HUND]};
  assign pre_ud        = {pre_reg[P_UD+1], pre_reg[P_UD]};

  // ****************************************
  // Single-input timers
  // ****************************************
  logic [15:0] tenth_reg;
  logic [15:0] hund_reg;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tenth_reg <= 16'h0000;
    end else if (!RUNG.tenth_en) begin
      tenth_reg <= 16'h0000;
    end else if (tenth_tick) begin
      tenth_reg <= 16'(bcd_inc({16'h0000, tenth_reg}, 4));
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hund_reg <= 16'h0000;
    end else if (!RUNG.hund_en) begin
      hund_reg <= 16'h0000;
    end else if (hund_tick) begin
      hund_reg <= 16'(bcd_inc({16'h0000, hund_reg}, 4));
    end
  end

  // ****************************************
  // Accumulating timers
  // ****************************************
  logic [31:0] acc_tenth_reg;
  logic [31:0] acc_hund_reg;

  // Reset has priority over enable
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      acc_tenth_reg <= 32'h0000_0000;
    end else if (RUNG.acc_tenth_rst) begin
      acc_tenth_reg <= 32'h0000_0000;
    end else if (RUNG.acc_tenth_en && tenth_tick) begin
      acc_tenth_reg <= bcd_inc(acc_tenth_reg, 8);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      acc_hund_reg <= 32'h0000_0000;
    end else if (RUNG.acc_hund_rst) begin
      acc_hund_reg <= 32'h0000_0000;
    end else if (RUNG.acc_hund_en && hund_tick) begin
      acc_hund_reg <= bcd_inc(acc_hund_reg, 8);
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  logic        up_prev_reg;
  logic        udu_prev_reg;
  logic        udd_prev_reg;
  logic        stg_prev_reg;
  logic [15:0] up_reg;
  logic [31:0] ud_reg;
  logic [15:0] stg_reg;
  logic        up_edge;
  logic        udu_edge;
  logic        udd_edge;
  logic        stg_edge;

  // Rung inputs come from the same clock, so no synchroniser
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      up_prev_reg  <= 1'b0;
      udu_prev_reg <= 1'b0;
      udd_prev_reg <= 1'b0;
      stg_prev_reg <= 1'b0;
    end else begin
      up_prev_reg  <= RUNG.up_in;
      udu_prev_reg <= RUNG.ud_up;
      udd_prev_reg <= RUNG.ud_down;
      stg_prev_reg <= RUNG.stg_in;
    end
  end

  assign up_edge  = RUNG.up_in && !up_prev_reg;
  assign udu_edge = RUNG.ud_up && !udu_prev_reg;
  assign udd_edge = RUNG.ud_down && !udd_prev_reg;
  assign stg_edge = RUNG.stg_in && !stg_prev_reg;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      up_reg <= 16'h0000;
    end else if (RUNG.up_rst) begin
      up_reg <= 16'h0000;
    end else if (up_edge) begin
      up_reg <= 16'(bcd_inc({16'h0000, up_reg}, 4));
    end
  end

  // Both edges at once cancel: neither condition holds
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ud_reg <= 32'h0000_0000;
    end else if (RUNG.ud_rst) begin
      ud_reg <= 32'h0000_0000;
    end else if (udu_edge && !RUNG.ud_down) begin
      ud_reg <= bcd_inc(ud_reg, 8);
    end else if (udd_edge && !RUNG.ud_up) begin
      ud_reg <= bcd_dec(ud_reg);
    end
  end

  // Clears only by the reset instruction, never by the count input
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      stg_reg <= 16'h0000;
    end else if (RUNG.stg_rst) begin
      stg_reg <= 16'h0000;
    end else if (stg_edge) begin
      stg_reg <= 16'(bcd_inc({16'h0000, stg_reg}, 4));
    end
  end

  // ****************************************
  // Done bits
  // ****************************************
  // Packed decimal orders like binary, so a plain compare suffices
  always_comb begin
    DONE.tenth     = tenth_reg >= pre_reg[P_TENTH];
    DONE.hund      = hund_reg >= pre_reg[P_HUND];
    DONE.acc_tenth = acc_tenth_reg >= pre_acc_tenth;
    DONE.acc_hund  = acc_hund_reg >= pre_acc_hund;
    DONE.up        = up_reg >= pre_reg[P_UP];
    DONE.ud        = ud_reg >= pre_ud;
    DONE.stg       = stg_reg >= pre_reg[P_STG];
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [15:0] rd_next;

  always_comb begin
    rd_next = 16'h0000;
    if (pre_hit) begin
      rd_next = pre_reg[pre_idx[3:0]];
    end else begin
      case (ADDR)
        TMR_BASE + T_TENTH:       rd_next = tenth_reg;
        TMR_BASE + T_HUND:        rd_next = hund_reg;
        TMR_BASE + T_ACC_TENTH:   rd_next = acc_tenth_reg[15:0];
        TMR_BASE + T_ACC_TENTH + 12'h001:
          rd_next = acc_tenth_reg[31:16];
        TMR_BASE + T_ACC_HUND:    rd_next = acc_hund_reg[15:0];
        TMR_BASE + T_ACC_HUND + 12'h001:
          rd_next = acc_hund_reg[31:16];
        CNT_BASE + C_UP:          rd_next = up_reg;
        CNT_BASE + C_UD:          rd_next = ud_reg[15:0];
        CNT_BASE + C_UD + 12'h001: rd_next = ud_reg[31:16];
        CNT_BASE + C_STG:         rd_next = stg_reg;
        default:                  rd_next = 16'h0000;
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= rd_next;
    end else begin
      RDATA <= 16'h0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_pre_write;
    WR && ADDR == PRE_BASE;
  endsequence

  sequence s_pre_read;
    RD && ADDR == PRE_BASE;
  endsequence

  a_tmr_input_drop: assert property (
    !RUNG.tenth_en |=> tenth_reg == 16'h0000 &&
                       DONE.tenth == (pre_reg[P_TENTH] == 16'h0000))
    else $error("tenth timer not cleared by input drop");

  a_tmr_tick_only: assert property (
    RUNG.tenth_en && !tenth_tick |=> $stable(tenth_reg))
    else $error("tenth timer moved without a tick");

  a_tick_spacing: assert property (
    hund_tick |=> !hund_tick)
    else $error("hundredth ticks back to back");

  a_acc_hold_value: assert property (
    !RUNG.acc_hund_en && !RUNG.acc_hund_rst |=> $stable(acc_hund_reg))
    else $error("accumulator changed while disabled");

  a_acc_reset_zero: assert property (
    RUNG.acc_tenth_rst |=> acc_tenth_reg == 32'h0000_0000)
    else $error("accumulator not zero under reset");

  a_cnt_reset_zero: assert property (
    RUNG.up_rst |=> up_reg == 16'h0000)
    else $error("up counter not zero under reset");

  a_cnt_ceiling_hold: assert property (
    up_reg == WORD_MAX && !RUNG.up_rst |=> up_reg == WORD_MAX)
    else $error("up counter left its ceiling");

  a_cnt_edge_step: assert property (
    $rose(RUNG.up_in) && !RUNG.up_rst && up_reg != WORD_MAX
      |=> up_reg != $past(up_reg))
    else $error("up counter missed an edge");

  a_ud_conflict_hold: assert property (
    RUNG.ud_up && RUNG.ud_down && !RUNG.ud_rst |=> $stable(ud_reg))
    else $error("up/down counter moved with both inputs on");

  a_stg_keep_value: assert property (
    !RUNG.stg_rst && !stg_edge |=> $stable(stg_reg))
    else $error("stage counter changed without edge or reset");

  a_preset_readback: assert property (
    s_pre_write ##1 s_pre_read |=> RDATA == $past(WDATA, 2))
    else $error("preset write not read back");

endmodule
`default_nettype wire

// *** test/rung_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rung_model
  import plc_tc_pkg::*;
(
  input  wire logic clk,
  output var rung_in_t rung
);
  initial rung = '0;

  // Level change just after an edge, held until the next call
  task automatic set(input int b, input logic v);
    @(posedge clk);
    rung[b] <= v;
  endtask

  // Low for a full cycle after each rise so the next rise is a real edge
  task automatic pulse(input int b);
    set(b, 1'b1);
    set(b, 1'b0);
  endtask
endmodule
`default_nettype wire

// *** test/plc_timer_counter_unit_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module plc_timer_counter_unit_bench
  import plc_tc_pkg::*;
;
  localparam int B_TEN = 12;
  localparam int B_HUN = 11;
  localparam int B_ATE = 10;
  localparam int B_ATR = 9;
  localparam int B_AHE = 8;
  localparam int B_AHR = 7;
  localparam int B_UP  = 6;
  localparam int B_UPR = 5;
  localparam int B_UDU = 4;
  localparam int B_UDD = 3;
  localparam int B_UDR = 2;
  localparam int B_STG = 1;
  localparam int B_STR = 0;

  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [11:0] addr    = 12'h000;
  logic [15:0] wdata   = 16'h0000;
  logic        wr_stb  = 1'b0;
  logic        rd_stb  = 1'b0;
  logic [15:0] rdata;
  logic [15:0] v;
  rung_in_t    rung;
  done_t       done;
  int          n_mismatch  = 0;
  int          check_count = 0;

  always #50 ref_clk = ~ref_clk;

  rung_model i_rung (.clk(ref_clk), .rung(rung));

  // Short time base keeps the timer scenarios to a few hundred cycles
  plc_timer_counter_unit #(.HUND_CYC(4)) i_dut (
    .REF_CLK(ref_clk),
    .RST    (rst),
    .ADDR   (addr),
    .WDATA  (wdata),
    .WR     (wr_stb),
    .RD     (rd_stb),
    .RDATA  (rdata),
    .RUNG   (rung),
    .DONE   (done)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Four-state result so an unknown read never passes a difference check
  function automatic logic [31:0] b2i(input logic [15:0] x);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 3; i >= 0; i--) begin
      r = r * 32'h0000_000a + 32'(x[4*i +: 4]);
    end
    return r;
  endfunction

  task automatic bus_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic bus_rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // Write then read with no gap between the strobes
  task automatic bus_wr_rd(input  logic [11:0] a,
                           input  logic [15:0] d,
                           output logic [15:0] q);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Two reads exactly span cycles apart must see ten steps
  task automatic rate(input logic [11:0] a, input int b, input int span,
                      input int db);
    logic [15:0] v1;
    logic [15:0] v2;
    i_rung.set(b, 1'b1);
    repeat (span) @(posedge ref_clk);
    bus_rd(a, v1);
    repeat (span - 2) @(posedge ref_clk);
    bus_rd(a, v2);
    `CHK(b2i(v2) - b2i(v1), 32'h0000_000a)
    `CHK(done[db], 1'b1)
    i_rung.set(b, 1'b0);
    settle();
    `CHK(done[db], 1'b0)
    bus_rd(a, v1);
    `CHK(v1, 16'h0000)
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    bus_rd(PRE_BASE, v);
    `CHK(v, PRE_RST)
    bus_rd(12'h7ff, v);
    `CHK(v, 16'h0000)
    bus_wr_rd(PRE_BASE, 16'h0005, v);
    `CHK(v, 16'h0005)
    bus_wr(PRE_BASE + 12'h001, 16'h0005);
    rate(TMR_BASE + T_TENTH, B_TEN, 400, 6);
    rate(TMR_BASE + T_HUND, B_HUN, 40, 5);
    bus_wr(PRE_BASE + 12'h006, 16'h0003);
    bus_rd(PRE_BASE + 12'h006, v);
    `CHK(v, 16'h0003)
    repeat (2) i_rung.pulse(B_UP);
    settle();
    `CHK(done.up, 1'b0)
    i_rung.pulse(B_UP);
    settle();
    `CHK(done.up, 1'b1)
    bus_rd(CNT_BASE + C_UP, v);
    `CHK(v, 16'h0003)
    for (int i = 0; i < 9997; i++) i_rung.pulse(B_UP);
    bus_wr(CNT_BASE + C_UP, 16'h1234);
    bus_rd(CNT_BASE + C_UP, v);
    `CHK(v, WORD_MAX)
    i_rung.set(B_UPR, 1'b1);
    i_rung.pulse(B_UP);
    settle();
    bus_rd(CNT_BASE + C_UP, v);
    `CHK(v, 16'h0000)
    `CHK(done.up, 1'b0)
    i_rung.set(B_UPR, 1'b0);
    repeat (3) i_rung.pulse(B_UDU);
    i_rung.pulse(B_UDD);
    i_rung.set(B_UDD, 1'b1);
    i_rung.pulse(B_UDU);
    i_rung.set(B_UDD, 1'b0);
    settle();
    bus_rd(CNT_BASE + C_UD, v);
    `CHK(v, 16'h0001)
    bus_rd(CNT_BASE + C_UD + 12'h001, v);
    `CHK(v, 16'h0000)
    bus_wr(PRE_BASE + 12'h007, 16'h0001);
    bus_wr(PRE_BASE + 12'h008, 16'h0000);
    settle();
    `CHK(done.ud, 1'b1)
    i_rung.set(B_UDR, 1'b1);
    i_rung.pulse(B_UDU);
    settle();
    bus_rd(CNT_BASE + C_UD, v);
    `CHK(v, 16'h0000)
    `CHK(done.ud, 1'b0)
    i_rung.set(B_UDR, 1'b0);
    bus_wr(PRE_BASE + 12'h009, 16'h0002);
    repeat (2) i_rung.pulse(B_STG);
    settle();
    `CHK(done.stg, 1'b1)
    bus_rd(CNT_BASE + C_STG, v);
    `CHK(v, 16'h0002)
    i_rung.set(B_STR, 1'b1);
    settle();
    bus_rd(CNT_BASE + C_STG, v);
    `CHK(v, 16'h0000)
    i_rung.set(B_STR, 1'b0);
    bus_wr(PRE_BASE + 12'h004, 16'h0005);
    bus_wr(PRE_BASE + 12'h005, 16'h0000);
    i_rung.set(B_AHE, 1'b1);
    repeat (39) @(posedge ref_clk);
    i_rung.set(B_AHE, 1'b0);
    settle();
    `CHK(done.acc_hund, 1'b1)
    bus_rd(TMR_BASE + T_ACC_HUND, v);
    `CHK(v, 16'h0010)
    repeat (40) @(posedge ref_clk);
    bus_rd(TMR_BASE + T_ACC_HUND, v);
    `CHK(v, 16'h0010)
    bus_rd(TMR_BASE + T_ACC_HUND + 12'h001, v);
    `CHK(v, 16'h0000)
    i_rung.set(B_AHR, 1'b1);
    i_rung.set(B_AHE, 1'b1);
    repeat (40) @(posedge ref_clk);
    bus_rd(TMR_BASE + T_ACC_HUND, v);
    `CHK(v, 16'h0000)
    `CHK(done.acc_hund, 1'b0)
    bus_wr(PRE_BASE + 12'h002, 16'h0001);
    bus_wr(PRE_BASE + 12'h003, 16'h0000);
    i_rung.set(B_ATE, 1'b1);
    repeat (39) @(posedge ref_clk);
    i_rung.set(B_ATE, 1'b0);
    settle();
    `CHK(done.acc_tenth, 1'b1)
    bus_rd(TMR_BASE + T_ACC_TENTH, v);
    `CHK(v, 16'h0001)
    i_rung.set(B_ATR, 1'b1);
    settle();
    bus_rd(TMR_BASE + T_ACC_TENTH, v);
    `CHK(v, 16'h0000)
    `CHK(done.acc_tenth, 1'b0)
    results();
  end

  // Whole sequence is about 21000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
